//--- hw/fieldbus_dp_master_cycle.sv
// Token holding and cyclic slave sequencer of a fieldbus master
//
// Notes on behaviour
// RL1: Address slaves only while holding the token.
// RL2: Token holder may send unsolicited frames.
// RL3: Retention time is a configured setting.
// RL4: Retention expiry passes token to next master.
// RL5: Slaves only answer after a request.
// RL6: Poll assigned slaves in fixed repeating order.
// RL7: Skip slaves excluded from cyclic exchange.
// RL8: Parameterize, then configure, then exchange data.
// RL9: Compare expected and reported configuration first.
// RL10: Compare type, format/length, input and output counts.
// RL11: Exchange sends fresh outputs, receives latest inputs.
// RL12: New configuration may be sent on request.
// RL13: Mismatch keeps slave out until check passes.
// RL14: Exchange decoupled through separate send/receive buffers; only a receive FIFO here, outputs are read straight from out_data_i.
`timescale 1ns/1ns
`include "dp_cycle_consts.svh"
module fieldbus_dp_master_cycle #(
  parameter int NSLV        = 8,
  parameter int RESP_WAIT   = `DP_RESP_TIMEOUT_CYC,
  parameter int FIFO_DEPTH  = `DP_IN_FIFO_DEPTH
) (
  input  wire logic                          clk_i,
  input  wire logic                          nrst_i,
  input  wire logic [15:0]                   hold_cycles_i,
  input  wire logic                          token_in_i,
  output logic                               token_pass_o,
  output logic                               token_held_o,
  input  wire logic [NSLV-1:0]               slave_en_i,
  input  wire dp_cycle_pkg::slave_cfg_type [NSLV-1:0] exp_cfg_i,
  input  wire logic [NSLV-1:0][15:0]         out_data_i,
  input  wire logic                          reconf_req_i,
  input  wire logic [6:0]                    reconf_slave_i,
  output logic                               req_valid_o,
  input  wire logic                          req_ready_i,
  output dp_cycle_pkg::request_type          req_o,
  input  wire logic                          resp_valid_i,
  input  wire dp_cycle_pkg::response_type    resp_i,
  output logic                               cfg_mismatch_o,
  output logic                               resp_timeout_o,
  output logic [NSLV-1:0]                    xchg_active_o,
  output logic                               in_valid_o,
  input  wire logic                          in_ready_i,
  output dp_cycle_pkg::in_word_type          in_word_o
);
  import dp_cycle_pkg::*;

  localparam int PW = (NSLV > 1) ? $clog2(NSLV) : 1;
  localparam int TW = $clog2(RESP_WAIT + 1);

  // Sequencer states, Gray from idle through select and send to wait
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_SELECT = 3'h1,
    ST_SEND   = 3'h3,
    ST_WAIT   = 3'h2,
    ST_PASS   = 3'h6
  } seq_state_type;

  seq_state_type  state_q, state_d;
  logic [PW-1:0]  ptr_q;
  logic [15:0]    hold_q;
  logic [TW-1:0]  wait_q;
  logic           token_q;
  logic           pass_q;
  logic           req_valid_q;
  request_type    req_q;
  logic           mism_q;
  logic           tmo_q;
  phase_type      phase_q   [NSLV];
  logic [NSLV-1:0] pend_q;
  logic [NSLV-1:0] xchg_q;
  logic           out_valid_q;
  in_word_type    out_word_q;

  // Decode of the current visit
  wire            expired   = (hold_q == 16'h0000);
  wire [PW-1:0]   ptr_nx    = (ptr_q == PW'(NSLV-1)) ? '0 : ptr_q + 1'b1;
  wire            cur_en    = slave_en_i[ptr_q];
  wire            cur_pend  = pend_q[ptr_q];
  wire phase_type cur_phase = cur_pend ? PH_PARAM : phase_q[ptr_q];
  wire [6:0]      cur_addr  = 7'(ptr_q);
  wire            resp_take = (state_q == ST_WAIT) && resp_valid_i;
  wire            wait_end  = (wait_q == TW'(RESP_WAIT));
  wire            timeout   = (state_q == ST_WAIT) && !resp_valid_i
                              && wait_end;
  // Expected against reported configuration, every field
  wire            cfg_ok    = (resp_i.cfg == exp_cfg_i[ptr_q]); // RL10
  wire            fifo_ready;
  wire            fifo_valid;
  in_word_type    fifo_word;
  wire            fifo_push = resp_take && req_q.kind == KIND_XCHG
                              && resp_i.kind == KIND_XCHG;
  wire            fifo_pop  = fifo_valid && (!out_valid_q || in_ready_i);
  // Exchange waits while the receive buffer has no room
  wire            can_send  = (cur_phase != PH_XCHG) || fifo_ready; // RL14
  wire            go_send   = (state_q == ST_SELECT) && !expired
                              && cur_en && can_send;
  wire            skip      = (state_q == ST_SELECT) && !expired
                              && !cur_en; // RL7
  wire            advance   = skip || resp_take || timeout; // RL6

  // Next state of the sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:   if (token_in_i) state_d = ST_SELECT; // RL1
      ST_SELECT: begin
        if (expired) state_d = ST_PASS; // RL4
        else if (go_send) state_d = ST_SEND;
      end
      ST_SEND:   if (req_ready_i) state_d = ST_WAIT;
      ST_WAIT:   if (resp_valid_i || wait_end) state_d = ST_SELECT; // RL5
      ST_PASS:   state_d = ST_IDLE;
      default:   state_d = ST_IDLE;
    endcase
  end

  // State, pointer and token ownership
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= ST_IDLE;
      ptr_q   <= '0;
      token_q <= 1'b0;
      pass_q  <= 1'b0;
    end else begin
      state_q <= state_d;
      if (advance) ptr_q <= ptr_nx; // RL6
      token_q <= (state_d != ST_IDLE) && (state_d != ST_PASS); // RL1
      pass_q  <= (state_d == ST_PASS); // RL4
    end
  end

  // Retention timer, loaded from the configured setting
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) hold_q <= `DP_HOLD_RST;
    else if (state_q == ST_IDLE && token_in_i) hold_q <= hold_cycles_i; // RL3
    else if (token_q && !expired) hold_q <= hold_q - 16'h0001; // RL4
  end

  // Answer timeout counter
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) wait_q <= '0;
    else if (state_q != ST_WAIT) wait_q <= '0;
    else if (!wait_end) wait_q <= wait_q + 1'b1;
  end

  // Request frame, built only while the token is held
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      req_valid_q <= 1'b0;
      req_q       <= '0;
    end else if (go_send) begin
      req_valid_q <= 1'b1; // RL1 RL2
      req_q.addr  <= cur_addr;
      req_q.kind  <= (cur_phase == PH_PARAM) ? KIND_PARAM
                   : (cur_phase == PH_CFG) ? KIND_CFG : KIND_XCHG; // RL8
      req_q.data  <= (cur_phase == PH_XCHG) ? out_data_i[ptr_q]
                   : 16'h0000; // RL11
    end else if (req_ready_i) begin
      req_valid_q <= 1'b0;
    end
  end

  // Per-slave phase and pending reconfiguration
  for (genvar i = 0; i < NSLV; i++) begin : g_slv
    wire here   = (ptr_q == PW'(i));
    wire rq_hit = reconf_req_i && (reconf_slave_i == 7'(i));
    // A new request wins over the clear at the visit
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) pend_q[i] <= 1'b0;
      else if (rq_hit) pend_q[i] <= 1'b1; // RL12
      else if (go_send && here) pend_q[i] <= 1'b0;
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) phase_q[i] <= phase_type'(`DP_PHASE_RST);
      else if (go_send && here && cur_pend) phase_q[i] <= PH_PARAM; // RL12
      else if (resp_take && here) begin
        case (req_q.kind)
          KIND_PARAM: phase_q[i] <= PH_CFG; // RL8
          KIND_CFG:   phase_q[i] <= cfg_ok ? PH_XCHG : PH_CFG; // RL9 RL13
          default:    phase_q[i] <= phase_q[i];
        endcase
      end
    end
    always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) xchg_q[i] <= 1'b0;
      else xchg_q[i] <= (phase_q[i] == PH_XCHG);
    end
  end

  // Error pulses
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mism_q <= 1'b0;
      tmo_q  <= 1'b0;
    end else begin
      mism_q <= resp_take && req_q.kind == KIND_CFG && !cfg_ok; // RL13
      tmo_q  <= timeout;
    end
  end

  // Receive buffer between the bus exchange and the user side
  xfer_fifo #(
    .WIDTH ($bits(in_word_type)),
    .DEPTH (FIFO_DEPTH)
  ) u_in_fifo (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .in_valid_i  (fifo_push),
    .in_ready_o  (fifo_ready),
    .in_data_i   ({req_q.addr, resp_i.data}),
    .out_valid_o (fifo_valid),
    .out_ready_i (fifo_pop),
    .out_data_o  (fifo_word)
  ); // RL14

  // Output register stage in front of the user
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      out_valid_q <= 1'b0;
      out_word_q  <= '0;
    end else if (fifo_pop) begin
      out_valid_q <= 1'b1; // RL11
      out_word_q  <= fifo_word;
    end else if (in_ready_i) begin
      out_valid_q <= 1'b0;
    end
  end

  assign token_pass_o   = pass_q;
  assign token_held_o   = token_q;
  assign req_valid_o    = req_valid_q;
  assign req_o          = req_q;
  assign cfg_mismatch_o = mism_q;
  assign resp_timeout_o = tmo_q;
  assign xchg_active_o  = xchg_q;
  assign in_valid_o     = out_valid_q;
  assign in_word_o      = out_word_q;
endmodule

//--- hw/dp_cycle_consts.svh
// Constants for the fieldbus master cycle sequencer
`ifndef DP_CYCLE_CONSTS_SVH
`define DP_CYCLE_CONSTS_SVH

// Clock period of clk_i in nanoseconds
`define DP_CLK_PERIOD_NS   20
// Longest wait for a slave answer, in nanoseconds
`define DP_RESP_TIMEOUT_NS 20000
// The same wait in clock cycles, rounded down
`define DP_RESP_TIMEOUT_CYC (`DP_RESP_TIMEOUT_NS / `DP_CLK_PERIOD_NS)
// Depth of the input data buffer
`define DP_IN_FIFO_DEPTH   4
// Reset value of the token retention timer
`define DP_HOLD_RST        16'h0000
// Reset value of the per-slave phase
`define DP_PHASE_RST       2'h0

`endif

//--- hw/dp_cycle_pkg.sv
// Types shared by the fieldbus master cycle sequencer
package dp_cycle_pkg;

  // Frame kinds sent to a slave
  typedef enum logic [1:0] {
    KIND_PARAM = 2'h0,
    KIND_CFG   = 2'h1,
    KIND_XCHG  = 2'h3
  } frame_kind_type;

  // Per-slave phase, Gray along the usual path
  typedef enum logic [1:0] {
    PH_PARAM = 2'h0,
    PH_CFG   = 2'h1,
    PH_XCHG  = 2'h3
  } phase_type;

  // Configuration a slave is expected to report
  typedef struct packed {
    logic [7:0] dev_type;
    logic [7:0] fmt_len;
    logic [3:0] n_in;
    logic [3:0] n_out;
  } slave_cfg_type;

  // Request frame to a slave
  typedef struct packed {
    frame_kind_type kind;
    logic [6:0]     addr;
    logic [15:0]    data;
  } request_type;

  // Answer frame from a slave
  typedef struct packed {
    frame_kind_type kind;
    slave_cfg_type  cfg;
    logic [15:0]    data;
  } response_type;

  // Word in the input buffer
  typedef struct packed {
    logic [6:0]  addr;
    logic [15:0] data;
  } in_word_type;

endpackage

//--- hw/xfer_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ns
module xfer_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 4
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  wire              push;
  wire              pop;
  wire  [AW-1:0]    wr_nx;
  wire  [AW-1:0]    rd_nx;

  // Honest full and empty from the fill count
  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;
  assign wr_nx = (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
  assign rd_nx = (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;

  // Pointers and count
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_nx;
      if (pop) rd_q <= rd_nx;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Storage, written by index
  always_ff @(posedge clk_i) begin
    if (push) mem_q[wr_q] <= in_data_i;
  end
endmodule

//--- tb/dp_cycle_properties.sv
// Port checker of the fieldbus master cycle sequencer
`timescale 1ns/1ns
module dp_cycle_properties #(
  parameter int NSLV = 8
) (
  input wire logic                      clk_i,
  input wire logic                      nrst_i,
  input wire logic [15:0]               hold_cycles_i,
  input wire logic                      token_in_i,
  input wire logic                      token_pass_o,
  input wire logic                      token_held_o,
  input wire logic [NSLV-1:0]           slave_en_i,
  input wire logic                      req_valid_o,
  input wire logic                      req_ready_i,
  input wire dp_cycle_pkg::request_type  req_o,
  input wire logic                      resp_valid_i,
  input wire dp_cycle_pkg::response_type resp_i,
  input wire logic                      cfg_mismatch_o,
  input wire logic [NSLV-1:0]           xchg_active_o,
  input wire logic                      in_valid_o,
  input wire logic                      in_ready_i,
  input wire dp_cycle_pkg::in_word_type  in_word_o
);
  import dp_cycle_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Token handling, link requests and answers, input words
  a_req_with_token: assert property (req_valid_o |-> token_held_o)
    else $error("request issued without token");
  a_token_taken: assert property (
    token_in_i && !token_held_o && !token_pass_o |=> token_held_o)
    else $error("token not taken in idle");
  a_zero_hold: assert property (
    token_in_i && !token_held_o && !token_pass_o && hold_cycles_i == 16'h0
    |-> ##[1:4] token_pass_o)
    else $error("token kept with zero retention");
  a_pass_drops: assert property (
    token_pass_o |-> !token_held_o && $past(token_held_o))
    else $error("pass pulse without prior holding");
  a_req_stable: assert property (
    req_valid_o && !req_ready_i |=> req_valid_o && $stable(req_o))
    else $error("request changed before acceptance");
  a_skip_excluded: assert property (
    req_valid_o |-> slave_en_i[req_o.addr])
    else $error("excluded slave addressed");
  a_xchg_phase: assert property (
    req_valid_o && req_o.kind == KIND_XCHG |-> xchg_active_o[req_o.addr])
    else $error("exchange frame outside exchange phase");
  a_mismatch_cause: assert property (
    cfg_mismatch_o |-> $past(resp_valid_i) && $past(resp_i.kind) == KIND_CFG)
    else $error("mismatch without configuration answer");
  a_word_holds: assert property (
    in_valid_o && !in_ready_i |=> in_valid_o && $stable(in_word_o))
    else $error("input word dropped before taken");
endmodule

bind fieldbus_dp_master_cycle dp_cycle_properties #(.NSLV(NSLV)) u_props (
  .clk_i(clk_i), .nrst_i(nrst_i), .hold_cycles_i(hold_cycles_i),
  .token_in_i(token_in_i), .token_pass_o(token_pass_o),
  .token_held_o(token_held_o), .slave_en_i(slave_en_i),
  .req_valid_o(req_valid_o), .req_ready_i(req_ready_i), .req_o(req_o),
  .resp_valid_i(resp_valid_i), .resp_i(resp_i),
  .cfg_mismatch_o(cfg_mismatch_o), .xchg_active_o(xchg_active_o),
  .in_valid_o(in_valid_o), .in_ready_i(in_ready_i), .in_word_o(in_word_o));

//--- tb/slave_link_model.sv
// Behavioural model of the polled slaves behind the request link
`timescale 1ns/1ns
module slave_link_model #(
  parameter int NSLV = 8
) (
  input  wire logic                              clk_i,
  input  wire logic                              req_valid_i,
  input  wire dp_cycle_pkg::request_type          req_i,
  input  wire dp_cycle_pkg::slave_cfg_type [NSLV-1:0] rep_cfg_i,
  input  wire logic                              mute_i,
  input  wire logic [3:0]                        dly_i,
  output logic                                   req_ready_o,
  output logic                                   resp_valid_o,
  output dp_cycle_pkg::response_type              resp_o
);
  import dp_cycle_pkg::*;
  request_type r;
  // Accept after a delay, answer only what was asked, then scramble
  initial begin
    req_ready_o = 1'b0;
    resp_valid_o = 1'b0;
    resp_o = '1;
    forever begin
      @(posedge clk_i);
      if (req_valid_i) begin
        repeat (dly_i) @(posedge clk_i);
        req_ready_o <= 1'b1;
        @(posedge clk_i);
        r = req_i;
        req_ready_o <= 1'b0;
        repeat (dly_i) @(posedge clk_i);
        if (!mute_i) begin
          resp_valid_o <= 1'b1;
          resp_o <= '{r.kind, rep_cfg_i[r.addr], r.data ^ 16'h5a5a};
          @(posedge clk_i);
          resp_valid_o <= 1'b0;
          resp_o <= ~resp_o;
        end
      end
    end
  end
endmodule

//--- tb/fieldbus_dp_master_cycle_tb.sv
// Self-checking bench of the fieldbus master cycle sequencer
`timescale 1ns/1ns
module fieldbus_dp_master_cycle_tb;
  import dp_cycle_pkg::*;
  localparam int NS = 6;
  logic clk = 1'b0, nrst = 1'b0, token_in = 1'b0, token_pass, token_held;
  logic req_valid, req_ready, resp_valid, cfg_mismatch, resp_timeout;
  logic in_valid, in_ready = 1'b0, reconf_req = 1'b0, mute = 1'b0, first;
  logic [15:0] hold = 16'h0;
  logic [6:0] reconf_slave = 7'h0, last;
  logic [3:0] dly = 4'h0;
  logic [NS-1:0] slave_en = 6'b111011, xchg_active;
  logic [NS-1:0][15:0] out_data;
  slave_cfg_type [NS-1:0] exp_cfg, rep_cfg, bad;
  request_type req;
  response_type resp;
  in_word_type in_word;
  int err_count = 0, compares = 0, n_mis = 0, n_to = 0, n_par1 = 0;
  int n_words = 0;

  fieldbus_dp_master_cycle #(.NSLV(NS), .RESP_WAIT(20)) DUT (
    .clk_i(clk), .nrst_i(nrst), .hold_cycles_i(hold), .token_in_i(token_in),
    .token_pass_o(token_pass), .token_held_o(token_held),
    .slave_en_i(slave_en), .exp_cfg_i(exp_cfg), .out_data_i(out_data),
    .reconf_req_i(reconf_req), .reconf_slave_i(reconf_slave),
    .req_valid_o(req_valid), .req_ready_i(req_ready), .req_o(req),
    .resp_valid_i(resp_valid), .resp_i(resp), .cfg_mismatch_o(cfg_mismatch),
    .resp_timeout_o(resp_timeout), .xchg_active_o(xchg_active),
    .in_valid_o(in_valid), .in_ready_i(in_ready), .in_word_o(in_word));

  slave_link_model #(.NSLV(NS)) u_slaves (
    .clk_i(clk), .req_valid_i(req_valid), .req_i(req), .rep_cfg_i(rep_cfg),
    .mute_i(mute), .dly_i(dly), .req_ready_o(req_ready),
    .resp_valid_o(resp_valid), .resp_o(resp));

  // Clock of 20 ns
  initial forever #10 clk = ~clk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic results;
    if (err_count == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Next included slave after a given one
  function automatic logic [6:0] nxt(input logic [6:0] a);
    logic [6:0] n;
    n = a;
    do n = (n == 7'(NS - 1)) ? 7'h0 : n + 7'h1; while (!slave_en[n]);
    return n;
  endfunction

  // Watch accepted requests, pulses and delivered input words
  always @(posedge clk) begin
    if (resp_timeout) n_to++;
    if (cfg_mismatch) n_mis++;
    if (req_valid && req_ready) begin
      if (!first) chk(req.addr, nxt(last));
      if (req.kind == KIND_XCHG) chk(req.data, out_data[req.addr]);
      if (req.kind == KIND_PARAM && req.addr == 7'h1) n_par1++;
      first = 1'b0;
      last = req.addr;
    end
    if (in_valid && in_ready) begin
      n_words++;
      chk(in_word.data, out_data[in_word.addr] ^ 16'h5a5a);
    end
  end

  // Hand over a token and wait for it to come back out
  task automatic run_token(input logic [15:0] h);
    int i;
    first = 1'b1;
    @(posedge clk);
    hold     <= h;
    token_in <= 1'b1;
    @(posedge clk) token_in <= 1'b0;
    @(negedge clk) chk(token_held, 1'b1);
    for (i = 0; i < h + 300 && !token_pass; i++) @(negedge clk);
    if (!token_pass) begin
      err_count++;
      results();
    end else begin
      chk(token_held, 1'b0);
    end
  endtask

  task automatic sc_mismatch;
    @(posedge clk);
    in_ready <= 1'b0;
    run_token(16'd400);
    chk(xchg_active, 6'b000001);
    chk(n_mis >= 4, 1'b1);
    chk(in_valid, 1'b1);
    @(posedge clk) in_ready <= 1'b1;
    repeat (12) @(posedge clk);
    chk(n_words >= 4, 1'b1);
  endtask

  task automatic sc_recover;
    @(posedge clk);
    rep_cfg <= exp_cfg;
    dly <= 4'h2;
    for (int k = 0; k < NS; k++) out_data[k] <= 16'(16'hb000 + k);
    run_token(16'd600);
    chk(xchg_active, slave_en);
  endtask

  task automatic sc_timeout;
    @(posedge clk);
    mute <= 1'b1;
    n_to = 0;
    run_token(16'd100);
    chk(n_to >= 1, 1'b1);
    chk(xchg_active, slave_en);
    @(posedge clk) mute <= 1'b0;
  endtask

  task automatic sc_reconf;
    @(posedge clk);
    n_par1 = 0;
    reconf_slave <= 7'h1;
    reconf_req <= 1'b1;
    @(posedge clk) reconf_req <= 1'b0;
    run_token(16'd600);
    chk(n_par1 >= 1, 1'b1);
    chk(xchg_active[1], 1'b1);
  endtask

  initial begin
    for (int k = 0; k < NS; k++) begin
      exp_cfg[k] = '{8'(8'h10 + k), 8'h20, 4'h1, 4'h2};
      out_data[k] = 16'(16'h0a00 + k);
    end
    bad = exp_cfg;
    bad[1].dev_type = 8'h7e;
    bad[3].fmt_len = 8'h21;
    bad[4].n_in = 4'h3;
    bad[5].n_out = 4'h5;
    rep_cfg = bad;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({token_held, token_pass, req_valid, in_valid, xchg_active}, 0);
    run_token(16'h0);
    sc_mismatch();
    sc_recover();
    sc_timeout();
    sc_reconf();
    results();
  end
endmodule
